// [dv/init_sequencer_model.sv]
`timescale 1ns/1ps
module init_sequencer_model #(
  parameter int LATENCY = 8
) (
  input  wire logic                     clk_sys,
  input  wire logic                     crcBadMode,
  input  wire logic                     eepromLoadRequest,
  input  wire logic                     bufferInitRequest,
  input  wire sysctl_pkg::test_req_type testRequest,
  output logic                          eepromLoadDone,
  output logic                          eepromCrcBad,
  output logic                          bufferInitDone,
  output logic                          testAccessDone,
  output logic        [31:0]            testPointerIn,
  output logic        [3:0]             testFlagIn
);
  sysctl_pkg::test_req_type req;
  initial
  begin
    {eepromLoadDone, eepromCrcBad, bufferInitDone, testAccessDone} = 4'h0;
    testPointerIn = 32'h0000_0000;
    testFlagIn    = 4'h0;
  end
  // crc flag held until request drops, it is synced like done
  always
  begin
    @(posedge clk_sys iff eepromLoadRequest === 1'b1);
    repeat (LATENCY) @(negedge clk_sys);
    eepromCrcBad   = crcBadMode;
    eepromLoadDone = 1'b1;
    @(negedge clk_sys);
    eepromLoadDone = 1'b0;
    wait (eepromLoadRequest !== 1'b1);
    eepromCrcBad = 1'b0;
  end
  always
  begin
    @(posedge clk_sys iff bufferInitRequest === 1'b1);
    repeat (LATENCY) @(negedge clk_sys);
    bufferInitDone = 1'b1;
    @(negedge clk_sys);
    bufferInitDone = 1'b0;
    wait (bufferInitRequest !== 1'b1);
  end
  // read data valid only around done, scrambled afterwards
  always
  begin
    @(posedge clk_sys iff testRequest.start === 1'b1);
    req = testRequest;
    repeat (LATENCY) @(negedge clk_sys);
    testPointerIn  = {req.row, req.col, req.row, req.col} ^ 32'h5a5a_5a5a;
    testFlagIn     = req.col[3:0];
    testAccessDone = 1'b1;
    @(negedge clk_sys);
    testAccessDone = 1'b0;
    repeat (4) @(negedge clk_sys);
    testPointerIn = ~testPointerIn;
    testFlagIn    = ~testFlagIn;
  end
endmodule // init_sequencer_model

// [dv/switch_system_control_regs_bench.sv]
`timescale 1ns/1ps
module switch_system_control_regs_bench;
  logic                       clk_sys = 1'b0;
  logic                       srst = 1'b1;
  logic                       crcBadMode = 1'b0;
  sysctl_pkg::cfg_access_type cfgAccess = '0;
  logic [7:0]                 cfgReadData;
  logic                       eepromLoadDone, eepromCrcBad, bufferInitDone, testAccessDone;
  logic [31:0]                testPointerIn;
  logic [3:0]                 testFlagIn, softwareIndicators;
  logic                       faultIndicator, partitionOnlyDisplay, flowControlEnable;
  logic                       postTagRouteEnable, softResetActive, portControlClear;
  logic                       hardResetPulse, eepromLoadRequest, bufferInitRequest;
  logic                       portsHeldOff, statisticsClear, statisticSelect;
  logic                       securityViolationDisable, testAccessUnlock;
  logic [17:0]                bufferCount;
  logic [10:0]                topBucketLimit;
  sysctl_pkg::test_req_type   testRequest, lastReq;
  int                         n_fail = 0, checks = 0, starts = 0, hrPulses = 0;

  always #2.5 clk_sys = ~clk_sys;

  switch_system_control_regs dut_u (.clk_sys, .srst, .cfgAccess, .cfgReadData,
    .eepromLoadDone, .eepromCrcBad, .bufferInitDone, .testAccessDone, .testPointerIn,
    .testFlagIn, .faultIndicator, .partitionOnlyDisplay, .softwareIndicators,
    .flowControlEnable, .postTagRouteEnable, .bufferCount, .softResetActive,
    .portControlClear, .hardResetPulse, .eepromLoadRequest, .bufferInitRequest,
    .portsHeldOff, .statisticsClear, .statisticSelect, .securityViolationDisable,
    .topBucketLimit, .testAccessUnlock, .testRequest);

  init_sequencer_model #(.LATENCY(8)) seq_u (.clk_sys, .crcBadMode, .eepromLoadRequest,
    .bufferInitRequest, .testRequest, .eepromLoadDone, .eepromCrcBad, .bufferInitDone,
    .testAccessDone, .testPointerIn, .testFlagIn);

  // pulses last a full cycle, so pre-update sampling still counts each once
  always @(posedge clk_sys)
  begin
    if (testRequest.start === 1'b1)
    begin
      starts++;
      lastReq = testRequest;
    end
    if (hardResetPulse === 1'b1)
      hrPulses++;
  end

  task automatic summarize();
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one idle cycle between accesses keeps each valid a single cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cfgAccess = '{1'b1, 1'b1, a, d};
    @(negedge clk_sys);
    cfgAccess.valid = 1'b0;
  endtask

  task automatic rdb(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    cfgAccess = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clk_sys);
    d = cfgReadData;
    cfgAccess.valid = 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdb(a, d);
    chk(d, e);
  endtask

  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic pollClear(input logic [15:0] a, input int b);
    logic [7:0] d;
    int         n;
    n = 0;
    rdb(a, d);
    while (d[b] !== 1'b0 && n < 60)
    begin
      rdb(a, d);
      n++;
    end
    chk(d[b], 1'b0);
  endtask

  task automatic resetValues();
    rchk(sysctl_pkg::ADDR_INDICATOR, 8'h00);
    rchk(sysctl_pkg::ADDR_MEMSIZE, 8'h04);
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h01);
    rchk(16'h0010, 8'h00);
    chk(bufferCount, 32'h0000_00f0);
    chk(topBucketLimit, sysctl_pkg::NORMAL_LIMIT);
    chk(portsHeldOff, 1'b1);
  endtask

  task automatic indicators();
    wr(sysctl_pkg::ADDR_INDICATOR, 8'hff);
    settle();
    rchk(sysctl_pkg::ADDR_INDICATOR, 8'h3f);
    chk(faultIndicator, 1'b1);
    chk(partitionOnlyDisplay, 1'b1);
    chk(softwareIndicators, 4'hf);
    wr(sysctl_pkg::ADDR_INDICATOR, 8'h05);
    settle();
    chk(faultIndicator, 1'b0);
    chk(partitionOnlyDisplay, 1'b0);
    chk(softwareIndicators, 4'h5);
  endtask

  task automatic memSize();
    for (int c = 4; c < 15; c++)
    begin
      wr(sysctl_pkg::ADDR_MEMSIZE, {4'h7, 4'(c)});
      settle();
      chk(bufferCount, 32'h0000_00f0 << (c - 4));
    end
    rchk(sysctl_pkg::ADDR_MEMSIZE, 8'h3e);
    chk(flowControlEnable, 1'b1);
    chk(postTagRouteEnable, 1'b1);
    wr(sysctl_pkg::ADDR_MEMSIZE, 8'h0f);
    settle();
    chk(bufferCount, 32'h0000_0000);
    chk(flowControlEnable, 1'b0);
    chk(postTagRouteEnable, 1'b0);
  endtask

  task automatic sysCtl();
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h1e);
    settle();
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h1f);
    repeat (20) @(negedge clk_sys);
    chk(statisticsClear, 1'b1);
    chk(statisticSelect, 1'b1);
    chk(securityViolationDisable, 1'b1);
    chk(topBucketLimit, sysctl_pkg::LONG_LIMIT);
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h00);
    settle();
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h01);
    chk({statisticsClear, statisticSelect, securityViolationDisable}, 3'h0);
    chk(topBucketLimit, sysctl_pkg::NORMAL_LIMIT);
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h80);
    settle();
    chk({softResetActive, portControlClear}, 2'h3);
    rchk(sysctl_pkg::ADDR_INDICATOR, 8'h05);
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h00);
    settle();
    chk({softResetActive, portsHeldOff}, 2'h1);
  endtask

  task automatic startRun();
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h20);
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h21);
    chk({bufferInitRequest, portsHeldOff}, 2'h3);
    pollClear(sysctl_pkg::ADDR_SYSCTL, sysctl_pkg::SYS_START_BIT);
    settle();
    chk(portsHeldOff, 1'b0);
  endtask

  task automatic loadRun();
    wr(sysctl_pkg::ADDR_MEMSIZE, 8'h84);
    crcBadMode = 1'b1;
    wr(sysctl_pkg::ADDR_SYSCTL, 8'h40);
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h41);
    chk({eepromLoadRequest, testAccessUnlock}, 2'h3);
    pollClear(sysctl_pkg::ADDR_SYSCTL, sysctl_pkg::SYS_LOAD_BIT);
    settle();
    crcBadMode = 1'b0;
    chk(testAccessUnlock, 1'b0);
    rchk(sysctl_pkg::ADDR_MEMSIZE, 8'h04);
    chk(faultIndicator, 1'b1);
  endtask

  task automatic testWrite();
    int s;
    wr(sysctl_pkg::ADDR_MEMSIZE, 8'h84);
    for (int i = 0; i < 4; i++)
      wr(sysctl_pkg::ADDR_PTR0 + 16'(i), 8'(8'h12 + 8'h22 * i));
    wr(sysctl_pkg::ADDR_FLAG, 8'h0a);
    s = starts;
    wr(sysctl_pkg::ADDR_LOC0, 8'h34);
    wr(sysctl_pkg::ADDR_LOC0 + 16'h0001, 8'h12);
    wr(sysctl_pkg::ADDR_LOC2, 8'ha5);
    rchk(sysctl_pkg::ADDR_FLAG, 8'h8a);
    // rewrite while busy must not start a second access
    wr(sysctl_pkg::ADDR_LOC2, 8'ha5);
    pollClear(sysctl_pkg::ADDR_FLAG, sysctl_pkg::FLAG_ACT_BIT);
    chk(starts - s, 1);
    chk({lastReq.toDram, lastReq.ext}, 7'h65);
    chk({lastReq.row, lastReq.col}, 16'h1234);
    chk(lastReq.pointer, 32'h7856_3412);
    chk(lastReq.flag, 4'ha);
  endtask

  task automatic testRead();
    wr(sysctl_pkg::ADDR_LOC0, 8'h0f);
    wr(sysctl_pkg::ADDR_LOC0 + 16'h0001, 8'h3c);
    wr(sysctl_pkg::ADDR_LOC2, 8'h00);
    pollClear(sysctl_pkg::ADDR_FLAG, sysctl_pkg::FLAG_ACT_BIT);
    chk({lastReq.toDram, lastReq.row}, 9'h03c);
    for (int i = 0; i < 4; i++)
      rchk(sysctl_pkg::ADDR_PTR0 + 16'(i), i[0] ? 8'h66 : 8'h55);
    rchk(sysctl_pkg::ADDR_FLAG, 8'h0f);
  endtask

  task automatic hwReset();
    int s;
    s = hrPulses;
    wr(16'h3fff, 8'h00);
    wr(16'h8000, 8'h00);
    settle();
    chk(hrPulses - s, 0);
    wr(sysctl_pkg::ADDR_HWRST_HI, 8'h00);
    settle();
    chk(hrPulses - s, 1);
    rchk(sysctl_pkg::ADDR_INDICATOR, 8'h00);
    rchk(sysctl_pkg::ADDR_MEMSIZE, 8'h04);
    rchk(sysctl_pkg::ADDR_SYSCTL, 8'h01);
  endtask

  initial
  begin
    #100000;
    n_fail++;
    summarize();
  end

  initial
  begin
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    resetValues();
    indicators();
    memSize();
    sysCtl();
    startRun();
    loadRun();
    testWrite();
    testRead();
    hwReset();
    summarize();
  end
endmodule // switch_system_control_regs_bench

// [include/sysctl_pkg.sv]
package sysctl_pkg;
  localparam logic [15:0] ADDR_INDICATOR   = 16'h00d1;
  localparam logic [15:0] ADDR_MEMSIZE     = 16'h00d2;
  localparam logic [15:0] ADDR_SYSCTL      = 16'h00d3;
  localparam logic [15:0] ADDR_PTR0        = 16'h00d4;
  localparam logic [15:0] ADDR_PTR3        = 16'h00d7;
  localparam logic [15:0] ADDR_FLAG        = 16'h00d8;
  localparam logic [15:0] ADDR_LOC0        = 16'h00d9;
  localparam logic [15:0] ADDR_LOC2        = 16'h00db;
  localparam logic [15:0] ADDR_TEST_LO     = 16'h00dc;
  localparam logic [15:0] ADDR_TEST_HI     = 16'h00ff;
  localparam logic [15:0] ADDR_HWRST_LO    = 16'h4000;
  localparam logic [15:0] ADDR_HWRST_HI    = 16'h7fff;
  localparam logic [7:0]  RST_INDICATOR    = 8'h00;
  localparam logic [7:0]  RST_MEMSIZE      = 8'h04;
  localparam logic [7:0]  RST_SYSCTL       = 8'h01;
  localparam logic [3:0]  SIZE_CODE_MIN    = 4'h4;
  localparam logic [3:0]  SIZE_CODE_RSVD   = 4'hf;
  localparam logic [17:0] BUFFERS_AT_MIN   = 18'h0_00f0;
  localparam int          IND_FAULT_BIT    = 5;
  localparam int          IND_PARTITION_ONLY_DISPLAY_BIT    = 4;
  localparam int          MEM_UNLOCK_BIT   = 7;
  localparam int          MEM_FLOW_BIT     = 5;
  localparam int          MEM_TAG_BIT      = 4;
  localparam int          SYS_RESET_BIT    = 7;
  localparam int          SYS_LOAD_BIT     = 6;
  localparam int          SYS_START_BIT    = 5;
  localparam int          SYS_CLR_BIT      = 4;
  localparam int          SYS_MAP_BIT      = 3;
  localparam int          SYS_SEC_BIT      = 2;
  localparam int          SYS_LONG_BIT     = 1;
  localparam int          FLAG_ACT_BIT     = 7;
  localparam int          LOC_DIR_BIT      = 23;
  localparam logic [10:0] LONG_LIMIT       = 11'h5fb;
  localparam logic [10:0] NORMAL_LIMIT     = 11'h5ee;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } cfg_access_type;

  typedef struct packed {
    logic        start;
    logic        toDram;
    logic [7:0]  row;
    logic [7:0]  col;
    logic [5:0]  ext;
    logic [31:0] pointer;
    logic [3:0]  flag;
  } test_req_type;

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} test_state_type;
endpackage

// [src/switch_system_control_regs.sv]
// Contract
// - fault indicator on by bit or bad load CRC
// - partition-only shows port enable state only
// - four software bits drive indicators directly
// - EEPROM load clears test unlock bit
// - flow enable gates collision flow control
// - post-tag bit selects uplink routing method
// - size code gives buffer count to initialise
// - soft reset clears port control, ports stay off
// - write to hardware reset range clears config
// - load bit reloads config, reads one until done
// - start bit initialises buffers, reads one until done
// - statistics clear repeats while bit is one
// - statistic select picks shared counter meaning
// - security bit chooses disable or suspend
// - long bit raises top bucket limit to 1531
// - in-order broadcast bit reads always one
// - pointer word carries buffer forward pointer
// - flag nibble carries buffer flag field
// - activity bit high while test access runs
// - location bit 23 picks transfer direction
// - access starts on location top byte write
// - location splits row, column, extended bits
`timescale 1ns/1ps
module switch_system_control_regs (
  input  wire logic                           clk_sys,
  input  wire logic                           srst,
  input  wire sysctl_pkg::cfg_access_type     cfgAccess,
  output logic        [7:0]                   cfgReadData,
  input  wire logic                           eepromLoadDone,
  input  wire logic                           eepromCrcBad,
  input  wire logic                           bufferInitDone,
  input  wire logic                           testAccessDone,
  input  wire logic   [31:0]                  testPointerIn,
  input  wire logic   [3:0]                   testFlagIn,
  output logic                                faultIndicator,
  output logic                                partitionOnlyDisplay,
  output logic        [3:0]                   softwareIndicators,
  output logic                                flowControlEnable,
  output logic                                postTagRouteEnable,
  output logic        [17:0]                  bufferCount,
  output logic                                softResetActive,
  output logic                                portControlClear,
  output logic                                hardResetPulse,
  output logic                                eepromLoadRequest,
  output logic                                bufferInitRequest,
  output logic                                portsHeldOff,
  output logic                                statisticsClear,
  output logic                                statisticSelect,
  output logic                                securityViolationDisable,
  output logic        [10:0]                  topBucketLimit,
  output logic                                testAccessUnlock,
  output sysctl_pkg::test_req_type            testRequest
);
  logic [7:0]  indicatorQ, indicatorD;
  logic [7:0]  memSizeQ, memSizeD;
  logic [7:0]  sysCtlQ, sysCtlD;
  logic [31:0] pointerQ, pointerD;
  logic [3:0]  flagQ, flagD;
  logic [23:0] locationQ, locationD;
  logic        crcBadQ, crcBadD;
  sysctl_pkg::test_state_type testStateQ, testStateD;
  logic        wr;
  logic        hwReset;
  logic [1:0]  syncLoadQ, syncInitQ, syncCrcQ, syncTestQ;
  logic [35:0] testDataS1Q, testDataS2Q;
  logic [7:0]  readD;
  logic [17:0] bufCountD;

  // done strobes arrive from slower pin-side logic
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      syncLoadQ <= 2'h0;
      syncInitQ <= 2'h0;
      syncCrcQ  <= 2'h0;
      syncTestQ <= 2'h0;
      testDataS1Q <= 36'h0_0000_0000;
      testDataS2Q <= 36'h0_0000_0000;
    end
    else
    begin
      // data rides two flops too, so it is settled when the synced done arrives
      testDataS1Q <= {testPointerIn, testFlagIn};
      testDataS2Q <= testDataS1Q;
      syncLoadQ <= {syncLoadQ[0], eepromLoadDone};
      syncInitQ <= {syncInitQ[0], bufferInitDone};
      syncCrcQ  <= {syncCrcQ[0], eepromCrcBad};
      syncTestQ <= {syncTestQ[0], testAccessDone};
    end
  end

  assign wr = cfgAccess.valid && cfgAccess.write;
  assign hwReset = wr && cfgAccess.addr >= sysctl_pkg::ADDR_HWRST_LO
                   && cfgAccess.addr <= sysctl_pkg::ADDR_HWRST_HI;

  always_comb
  begin
    indicatorD = indicatorQ;
    memSizeD   = memSizeQ;
    sysCtlD    = sysCtlQ;
    pointerD   = pointerQ;
    flagD      = flagQ;
    locationD  = locationQ;
    crcBadD    = crcBadQ;
    testStateD = testStateQ;
    if (wr)
    begin
      case (cfgAccess.addr)
        sysctl_pkg::ADDR_INDICATOR: indicatorD = {2'h0, cfgAccess.data[5:0]};
        sysctl_pkg::ADDR_MEMSIZE:   memSizeD = {cfgAccess.data[7], 1'b0, cfgAccess.data[5:0]};
        sysctl_pkg::ADDR_SYSCTL:
        begin
          sysCtlD[sysctl_pkg::SYS_RESET_BIT] = cfgAccess.data[sysctl_pkg::SYS_RESET_BIT];
          // load and start are set-only; writing 0 leaves them alone
          if (cfgAccess.data[sysctl_pkg::SYS_LOAD_BIT])
            sysCtlD[sysctl_pkg::SYS_LOAD_BIT] = 1'b1;
          if (cfgAccess.data[sysctl_pkg::SYS_START_BIT])
            sysCtlD[sysctl_pkg::SYS_START_BIT] = 1'b1;
          sysCtlD[sysctl_pkg::SYS_CLR_BIT:sysctl_pkg::SYS_LONG_BIT] =
            cfgAccess.data[sysctl_pkg::SYS_CLR_BIT:sysctl_pkg::SYS_LONG_BIT];
        end
        sysctl_pkg::ADDR_FLAG: flagD = cfgAccess.data[3:0];
        default:
        begin
          // little endian byte lanes
          if (cfgAccess.addr >= sysctl_pkg::ADDR_PTR0 && cfgAccess.addr <= sysctl_pkg::ADDR_PTR3)
            pointerD[8*(cfgAccess.addr[1:0])+:8] = cfgAccess.data;
          if (cfgAccess.addr >= sysctl_pkg::ADDR_LOC0 && cfgAccess.addr <= sysctl_pkg::ADDR_LOC2)
            locationD[8*(2'(cfgAccess.addr - sysctl_pkg::ADDR_LOC0))+:8] = cfgAccess.data;
        end
      endcase
    end
    case (testStateQ)
      sysctl_pkg::ST_IDLE:
        if (wr && cfgAccess.addr == sysctl_pkg::ADDR_LOC2)
          testStateD = sysctl_pkg::ST_BUSY;
      sysctl_pkg::ST_BUSY:
        if (syncTestQ[1])
        begin
          testStateD = sysctl_pkg::ST_IDLE;
          if (!locationQ[sysctl_pkg::LOC_DIR_BIT])
          begin
            pointerD = testDataS2Q[35:4];
            flagD    = testDataS2Q[3:0];
          end
        end
      default: testStateD = sysctl_pkg::ST_IDLE;
    endcase
    if (syncLoadQ[1])
    begin
      // load ends: unlock forced off, load bit self-clears
      memSizeD[sysctl_pkg::MEM_UNLOCK_BIT] = 1'b0;
      sysCtlD[sysctl_pkg::SYS_LOAD_BIT] = 1'b0;
      crcBadD = syncCrcQ[1];
    end
    if (syncInitQ[1])
      sysCtlD[sysctl_pkg::SYS_START_BIT] = 1'b0;
    sysCtlD[0] = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || hwReset)
    begin
      indicatorQ <= sysctl_pkg::RST_INDICATOR;
      memSizeQ   <= sysctl_pkg::RST_MEMSIZE;
      sysCtlQ    <= sysctl_pkg::RST_SYSCTL;
      pointerQ   <= 32'h0000_0000;
      flagQ      <= 4'h0;
      locationQ  <= 24'h00_0000;
      crcBadQ    <= 1'b0;
      testStateQ <= sysctl_pkg::ST_IDLE;
    end
    else
    begin
      indicatorQ <= indicatorD;
      memSizeQ   <= memSizeD;
      sysCtlQ    <= sysCtlD;
      pointerQ   <= pointerD;
      flagQ      <= flagD;
      locationQ  <= locationD;
      crcBadQ    <= crcBadD;
      testStateQ <= testStateD;
    end
  end

  always_comb
  begin
    // reserved size code yields zero buffers
    if (memSizeQ[3:0] < sysctl_pkg::SIZE_CODE_MIN || memSizeQ[3:0] == sysctl_pkg::SIZE_CODE_RSVD)
      bufCountD = 18'h0_0000;
    else
      bufCountD = sysctl_pkg::BUFFERS_AT_MIN << (memSizeQ[3:0] - sysctl_pkg::SIZE_CODE_MIN);
    readD = 8'h00;
    case (cfgAccess.addr)
      sysctl_pkg::ADDR_INDICATOR: readD = indicatorQ;
      sysctl_pkg::ADDR_MEMSIZE:   readD = memSizeQ;
      sysctl_pkg::ADDR_SYSCTL:    readD = sysCtlQ;
      sysctl_pkg::ADDR_FLAG:
        readD = {testStateQ == sysctl_pkg::ST_BUSY, 3'h0, flagQ};
      default:
      begin
        if (cfgAccess.addr >= sysctl_pkg::ADDR_PTR0 && cfgAccess.addr <= sysctl_pkg::ADDR_PTR3)
          readD = pointerQ[8*(cfgAccess.addr[1:0])+:8];
        if (cfgAccess.addr >= sysctl_pkg::ADDR_LOC0 && cfgAccess.addr <= sysctl_pkg::ADDR_LOC2)
          readD = locationQ[8*(2'(cfgAccess.addr - sysctl_pkg::ADDR_LOC0))+:8];
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cfgReadData <= 8'h00;
      faultIndicator <= 1'b0;
      partitionOnlyDisplay <= 1'b0;
      softwareIndicators <= 4'h0;
      flowControlEnable <= 1'b0;
      postTagRouteEnable <= 1'b0;
      bufferCount <= 18'h0_0000;
      softResetActive <= 1'b0;
      portControlClear <= 1'b0;
      hardResetPulse <= 1'b0;
      eepromLoadRequest <= 1'b0;
      bufferInitRequest <= 1'b0;
      portsHeldOff <= 1'b1;
      statisticsClear <= 1'b0;
      statisticSelect <= 1'b0;
      securityViolationDisable <= 1'b0;
      topBucketLimit <= sysctl_pkg::NORMAL_LIMIT;
      testAccessUnlock <= 1'b0;
      testRequest <= '0;
    end
    else
    begin
      cfgReadData <= readD;
      faultIndicator <= indicatorQ[sysctl_pkg::IND_FAULT_BIT] || crcBadQ;
      partitionOnlyDisplay <= indicatorQ[sysctl_pkg::IND_PARTITION_ONLY_DISPLAY_BIT];
      softwareIndicators <= indicatorQ[3:0];
      flowControlEnable <= memSizeQ[sysctl_pkg::MEM_FLOW_BIT];
      postTagRouteEnable <= memSizeQ[sysctl_pkg::MEM_TAG_BIT];
      bufferCount <= bufCountD;
      softResetActive <= sysCtlQ[sysctl_pkg::SYS_RESET_BIT];
      portControlClear <= sysCtlQ[sysctl_pkg::SYS_RESET_BIT];
      hardResetPulse <= hwReset;
      eepromLoadRequest <= sysCtlQ[sysctl_pkg::SYS_LOAD_BIT];
      bufferInitRequest <= sysCtlQ[sysctl_pkg::SYS_START_BIT];
      // ports stay off through soft reset and buffer init
      // next start value: the old bit would mask the one-cycle done
      portsHeldOff <= sysCtlQ[sysctl_pkg::SYS_RESET_BIT]
                      || sysCtlD[sysctl_pkg::SYS_START_BIT] || portsHeldOff && !syncInitQ[1];
      statisticsClear <= sysCtlQ[sysctl_pkg::SYS_CLR_BIT];
      statisticSelect <= sysCtlQ[sysctl_pkg::SYS_MAP_BIT];
      securityViolationDisable <= sysCtlQ[sysctl_pkg::SYS_SEC_BIT];
      topBucketLimit <= sysCtlQ[sysctl_pkg::SYS_LONG_BIT] ? sysctl_pkg::LONG_LIMIT
                                                          : sysctl_pkg::NORMAL_LIMIT;
      testAccessUnlock <= memSizeQ[sysctl_pkg::MEM_UNLOCK_BIT];
      testRequest.start <= testStateQ == sysctl_pkg::ST_IDLE && testStateD == sysctl_pkg::ST_BUSY;
      testRequest.toDram <= locationD[sysctl_pkg::LOC_DIR_BIT];
      testRequest.row <= locationD[15:8];
      testRequest.col <= locationD[7:0];
      testRequest.ext <= locationD[21:16];
      testRequest.pointer <= pointerD;
      testRequest.flag <= flagD;
    end
  end

  property p_iob_one;
    @(posedge clk_sys) disable iff (srst) sysCtlQ[0];
  endproperty
  a_iob_one: assert property (p_iob_one) else $error("in-order bit low");

  property p_start_access;
    @(posedge clk_sys) disable iff (srst)
      (wr && cfgAccess.addr == sysctl_pkg::ADDR_LOC2 && testStateQ == sysctl_pkg::ST_IDLE
       && !hwReset) |=> testStateQ == sysctl_pkg::ST_BUSY ##0 testRequest.start;
  endproperty
  a_start_access: assert property (p_start_access) else $error("test access not started");

  property p_fault;
    @(posedge clk_sys) disable iff (srst)
      indicatorQ[sysctl_pkg::IND_FAULT_BIT] |=> faultIndicator;
  endproperty
  a_fault: assert property (p_fault) else $error("fault indicator off");

  property p_load_clears_unlock;
    @(posedge clk_sys) disable iff (srst) syncLoadQ[1] |=> !memSizeQ[sysctl_pkg::MEM_UNLOCK_BIT]
      ##0 !sysCtlQ[sysctl_pkg::SYS_LOAD_BIT];
  endproperty
  a_load_clears_unlock: assert property (p_load_clears_unlock) else $error("load end");

  property p_hw_reset;
    @(posedge clk_sys) disable iff (srst) hwReset |=> indicatorQ == sysctl_pkg::RST_INDICATOR
      ##0 sysCtlQ == sysctl_pkg::RST_SYSCTL ##0 hardResetPulse;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hardware reset missed");

  property p_active_read;
    @(posedge clk_sys) disable iff (srst) (cfgAccess.addr == sysctl_pkg::ADDR_FLAG)
      |=> cfgReadData[sysctl_pkg::FLAG_ACT_BIT] == $past(testStateQ == sysctl_pkg::ST_BUSY);
  endproperty
  a_active_read: assert property (p_active_read) else $error("activity bit wrong");

  property p_sw_led;
    @(posedge clk_sys) disable iff (srst)
      (wr && cfgAccess.addr == sysctl_pkg::ADDR_INDICATOR && !hwReset)
      |-> ##2 softwareIndicators == $past(cfgAccess.data[3:0], 2);
  endproperty
  a_sw_led: assert property (p_sw_led) else $error("software indicators wrong");

  property p_long;
    @(posedge clk_sys) disable iff (srst) sysCtlQ[sysctl_pkg::SYS_LONG_BIT]
      |=> topBucketLimit == sysctl_pkg::LONG_LIMIT;
  endproperty
  a_long: assert property (p_long) else $error("bucket limit wrong");
endmodule // switch_system_control_regs
